// ===== common/ctm_map.svh
// register offsets, field positions, reset values and timing constants of the compact timer
// assumes a 32-bit ahb-lite slave with one register per aligned word
`ifndef CTM_MAP_SVH
`define CTM_MAP_SVH

`define CTM_OFF_CTRL0 12'h000
`define CTM_OFF_CTRL1 12'h004
`define CTM_OFF_CNT_LO 12'h008
`define CTM_OFF_CNT_HI 12'h00c
`define CTM_OFF_CMPA_LO 12'h010
`define CTM_OFF_CMPA_HI 12'h014
`define CTM_OFF_FLAGS 12'h018
`define CTM_OFF_TICK 12'h01c

// ctrl0 fields
`define CTM_C0_PAUSE 7
`define CTM_C0_ENABLE 3
`define CTM_C0_PERIOD_LSB 0
// ctrl1 fields
`define CTM_C1_MODE_LSB 6
`define CTM_C1_FUNC_LSB 4
`define CTM_C1_OCTRL 3
`define CTM_C1_POL 2
`define CTM_C1_DPX 1
`define CTM_C1_CLR 0
// flags fields
`define CTM_FL_A 0
`define CTM_FL_P 1

`define CTM_RST_BYTE 8'h00
`define CTM_RST_TICK 16'h0000
`define CTM_PERIOD_SHIFT 7
`define CTM_CNT_MAX 10'h3ff

`endif

// ===== common/ctm_pkg.sv
// types shared by the compact timer and its bench
// assumes ctm_map.svh supplies the register offsets and field positions; the mode and function encodings are set here
package ctm_pkg;

    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_UNDEF = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TIMER = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        FUNC_NONE = 2'b00,
        FUNC_LOW = 2'b01,
        FUNC_HIGH = 2'b10,
        FUNC_TOGGLE = 2'b11
    } func_t;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
        logic hready;
    } ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } ahb_rsp_t;

    typedef struct packed {
        logic pin_out;
        logic pin_oe;
    } pin_t;

    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] cmpa_lo;
        logic [1:0] cmpa_hi;
        logic flag_a;
        logic flag_p;
        logic [15:0] tick_div;
        logic [15:0] div_cnt;
        logic [9:0] count;
        logic enable_d;
        logic level;
        logic wr_pend;
        logic [11:0] wr_addr;
    } state_t;

endpackage

// ===== core/compact_timer.sv
// compact 10-bit timer: compare match, timer/counter and pwm modes behind an ahb-lite slave
// assumes a single clock domain; the timer clock is a programmable divider of clk_sys
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ns
`include "ctm_map.svh"

module compact_timer
    import ctm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // ahb-lite slave
    input wire ctm_pkg::ahb_req_t ahb_req,
    input wire logic [31:0] hwdata,
    output ctm_pkg::ahb_rsp_t ahb_rsp,
    // timer output pin
    output ctm_pkg::pin_t pin
);
    import ctm_pkg::*;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // period/duty in timer clocks from the 3-bit period value
    function automatic logic [10:0] p_clocks(input logic [2:0] p);
        p_clocks = (p == 3'd0) ? 11'd1024 : {1'b0, p, 7'd0};
    endfunction

    function automatic logic [7:0] reg_read(input state_t s, input logic [11:0] a);
        case (a)
            `CTM_OFF_CTRL0: reg_read = s.ctrl0;
            `CTM_OFF_CTRL1: reg_read = s.ctrl1;
            `CTM_OFF_CNT_LO: reg_read = s.count[7:0];
            `CTM_OFF_CNT_HI: reg_read = {6'h00, s.count[9:8]};
            `CTM_OFF_CMPA_LO: reg_read = s.cmpa_lo;
            `CTM_OFF_CMPA_HI: reg_read = {6'h00, s.cmpa_hi};
            `CTM_OFF_FLAGS: reg_read = {6'h00, s.flag_p, s.flag_a};
            default: reg_read = 8'h00;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    state_t st_r;
    state_t st_nxt;

    logic wr_take;
    logic rd_take;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    mode_t mode;
    func_t func;
    logic enable;
    logic pause;
    logic clr_sel;
    logic dpx;
    logic octrl;
    logic pol;
    logic [2:0] period_v;
    logic [9:0] cmpa_v;
    logic tick;
    logic run;
    logic match_a;
    logic match_p;
    logic p_clear;
    logic a_clear;
    logic do_clear;
    logic set_a;
    logic set_p;
    logic [10:0] pwm_period;
    logic [10:0] pwm_duty;
    logic pwm_active;
    logic pwm_level;
    logic pin_raw;
    logic [7:0] wbyte;

    always_comb begin
        mode = mode_t'(st_r.ctrl1[`CTM_C1_MODE_LSB +: 2]);
        func = func_t'(st_r.ctrl1[`CTM_C1_FUNC_LSB +: 2]);
        enable = st_r.ctrl0[`CTM_C0_ENABLE];
        pause = st_r.ctrl0[`CTM_C0_PAUSE];
        period_v = st_r.ctrl0[`CTM_C0_PERIOD_LSB +: 3];
        clr_sel = st_r.ctrl1[`CTM_C1_CLR];
        dpx = st_r.ctrl1[`CTM_C1_DPX];
        octrl = st_r.ctrl1[`CTM_C1_OCTRL];
        pol = st_r.ctrl1[`CTM_C1_POL];
        cmpa_v = {st_r.cmpa_hi, st_r.cmpa_lo};
    end

    // ---------------------------------------------------------------
    // counter and comparators
    // ---------------------------------------------------------------
    always_comb begin
        tick = (st_r.div_cnt >= st_r.tick_div);
        run = enable && !pause && tick;
        // comparator p matches when the top three counter bits plus one equal the period value and the low seven bits are all ones
        p_clear = (st_r.count[9:7] + 3'd1 == period_v) && (st_r.count[6:0] == 7'h7f);
        a_clear = (st_r.count + 10'd1 == cmpa_v);
        // a match is the count that would reach the compare value, so a clear on it still flags
        match_p = run && (period_v != 3'd0) && p_clear;
        match_a = run && (cmpa_v != 10'd0) && a_clear;
        pwm_period = dpx ? {1'b0, cmpa_v} : p_clocks(period_v);
        pwm_duty = dpx ? p_clocks(period_v) : {1'b0, cmpa_v};
        // clear happens on the clock that would reach the match value so the match state lasts one count
        if (mode == MODE_PWM) begin
            if (dpx) begin
                do_clear = (cmpa_v != 10'd0) && a_clear;
            end else begin
                do_clear = (period_v != 3'd0) && p_clear;
            end
        end else if (clr_sel) begin
            do_clear = (cmpa_v != 10'd0) && a_clear;
        end else begin
            do_clear = (period_v != 3'd0) && p_clear;
        end
        set_a = match_a;
        set_p = match_p && ((mode == MODE_PWM) || !clr_sel);
        pwm_active = ({1'b0, st_r.count} < pwm_duty) || (pwm_duty >= pwm_period);
        pwm_level = pwm_active ? octrl : !octrl;
    end

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    always_comb begin
        wr_take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && ahb_req.hwrite;
        rd_take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && !ahb_req.hwrite;
        wbyte = hwdata[7:0];
        rdata_nxt = rd_take ? {24'h000000, reg_read(st_r, ahb_req.haddr[11:0])} : 32'h00000000;
        if (rd_take && ahb_req.haddr[11:0] == `CTM_OFF_TICK) begin
            rdata_nxt = {16'h0000, st_r.tick_div};
        end
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.wr_pend = wr_take;
        st_nxt.wr_addr = ahb_req.haddr[11:0];
        st_nxt.enable_d = enable;
        st_nxt.div_cnt = (tick || !enable) ? 16'h0000 : st_r.div_cnt + 16'h0001;
        if (enable && !st_r.enable_d) begin
            st_nxt.count = 10'd0;
            st_nxt.level = octrl;
        end else if (run) begin
            st_nxt.count = do_clear ? 10'd0 : st_r.count + 10'd1;
            if (match_a && (mode == MODE_COMPARE || mode == MODE_TIMER)) begin
                unique case (func)
                    FUNC_NONE: st_nxt.level = st_r.level;
                    FUNC_LOW: st_nxt.level = 1'b0;
                    FUNC_HIGH: st_nxt.level = 1'b1;
                    FUNC_TOGGLE: st_nxt.level = !st_r.level;
                endcase
            end
        end
        // software clears flags by writing one; a hardware set in the same cycle wins
        if (st_r.wr_pend) begin
            unique case (st_r.wr_addr)
                `CTM_OFF_CTRL0: st_nxt.ctrl0 = wbyte;
                `CTM_OFF_CTRL1: st_nxt.ctrl1 = wbyte;
                `CTM_OFF_CMPA_LO: st_nxt.cmpa_lo = wbyte;
                `CTM_OFF_CMPA_HI: st_nxt.cmpa_hi = wbyte[1:0];
                `CTM_OFF_FLAGS: begin
                    if (wbyte[`CTM_FL_A]) st_nxt.flag_a = 1'b0;
                    if (wbyte[`CTM_FL_P]) st_nxt.flag_p = 1'b0;
                end
                `CTM_OFF_TICK: st_nxt.tick_div = hwdata[15:0];
                default: st_nxt.ctrl0 = st_r.ctrl0;
            endcase
        end
        if (set_a) st_nxt.flag_a = 1'b1;
        if (set_p) st_nxt.flag_p = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            rdata_r <= 32'h00000000;
        end else begin
            st_r <= st_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    always_comb begin
        unique case (func)
            FUNC_NONE: pin_raw = !octrl;
            FUNC_LOW: pin_raw = octrl;
            default: pin_raw = pwm_level;
        endcase
        if (mode != MODE_PWM) begin
            pin_raw = st_r.level;
        end
        ahb_rsp.hrdata = rdata_r;
        ahb_rsp.hreadyout = 1'b1;
        ahb_rsp.hresp = 1'b0;
        pin.pin_out = pin_raw ^ pol;
        pin.pin_oe = (mode == MODE_COMPARE) || (mode == MODE_PWM);
    end

endmodule // compact_timer

// ===== verif/ctm_load.sv
// load model on the timer output pin: measures edge to edge period and high time
// assumes the pin has no pull, so a released pin shows the inverse of its last level
`timescale 1ns/1ns
module ctm_load
    import ctm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // pin and measurements
    input wire ctm_pkg::pin_t pin,
    output logic lvl,
    output logic [15:0] period_cyc,
    output logic [15:0] high_cyc
);
    logic last_r, prev_r;
    logic [15:0] cnt_r, hcnt_r;
    // floating line must not look like a held level
    assign lvl = pin.pin_oe ? pin.pin_out : ~last_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {last_r, prev_r, cnt_r, hcnt_r, period_cyc, high_cyc} <= '0;
        end else begin
            last_r <= lvl;
            prev_r <= lvl;
            if (lvl && !prev_r) begin
                period_cyc <= cnt_r + 16'h1;
                high_cyc <= hcnt_r;
                cnt_r <= '0;
                hcnt_r <= 16'h1;
            end else begin
                cnt_r <= cnt_r + 16'h1;
                hcnt_r <= hcnt_r + {15'h0, lvl};
            end
        end
    end
endmodule // ctm_load

// ===== verif/compact_timer_checker.sv
// port checker of the compact timer, bound to its top module
// assumes a zero wait-state slave, so a data phase is the cycle after its address phase
`timescale 1ns/1ns
`include "ctm_map.svh"
module compact_timer_checker
    import ctm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // bus and pin
    input wire ctm_pkg::ahb_req_t ahb_req,
    input wire logic [31:0] hwdata,
    input wire ctm_pkg::ahb_rsp_t ahb_rsp,
    input wire ctm_pkg::pin_t pin
);
    logic acc, wr_v_r, rd_v_r;
    logic [11:0] wr_a_r;
    logic [1:0] mode_r, func_r;
    logic [2:0] hist_r;
    assign acc = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
    // shadow of mode and function, updated at the same edge as the real register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {wr_v_r, rd_v_r, wr_a_r, mode_r, func_r, hist_r} <= '0;
        end else begin
            wr_v_r <= acc && ahb_req.hwrite;
            rd_v_r <= acc && !ahb_req.hwrite;
            wr_a_r <= ahb_req.haddr[11:0];
            hist_r <= {hist_r[1:0], wr_v_r};
            if (wr_v_r && wr_a_r == `CTM_OFF_CTRL1) begin
                mode_r <= hwdata[7:6];
                func_r <= hwdata[5:4];
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence rd_at(a);
        acc && !ahb_req.hwrite && ahb_req.haddr[11:0] == a;
    endsequence
    property rd_masked(a, m);
        rd_at(a) |=> (ahb_rsp.hrdata & m) == 32'h0;
    endproperty
    AST_OKAY: assert property (ahb_rsp.hresp == 1'b0)
        else $error("response not okay");
    AST_READY: assert property (ahb_rsp.hreadyout == 1'b1)
        else $error("wait state inserted");
    AST_CNT_HI: assert property (rd_masked(`CTM_OFF_CNT_HI, 32'hffff_fffc))
        else $error("counter high upper bits set");
    AST_CMPA_LO: assert property (rd_masked(`CTM_OFF_CMPA_LO, 32'hffff_ff00))
        else $error("compare a low wider than a byte");
    AST_CMPA_HI: assert property (rd_masked(`CTM_OFF_CMPA_HI, 32'hffff_fffc))
        else $error("compare a high upper bits set");
    AST_UNMAPPED: assert property (rd_at(12'h020) |=> ahb_rsp.hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_IDLE: assert property (!rd_v_r |-> ahb_rsp.hrdata == 32'h0)
        else $error("read data outside data phase");
    AST_OE: assert property (pin.pin_oe == (mode_r == 2'b00 || mode_r == 2'b10))
        else $error("pin enable does not follow mode");
    AST_PIN_HOLD: assert property (mode_r == 2'b00 && func_r == 2'b00 && hist_r == 3'h0
        && !wr_v_r |-> $stable(pin.pin_out))
        else $error("pin moved with no change function");
endmodule // compact_timer_checker
bind compact_timer compact_timer_checker i_compact_timer_checker (.clk_sys(clk_sys), .rst_n(rst_n),
    .ahb_req(ahb_req), .hwdata(hwdata), .ahb_rsp(ahb_rsp), .pin(pin));

// ===== verif/test_compact_timer.sv
// self-checking bench of the compact timer: register access, compare, timer and pwm modes
// assumes tick divider at reset value, so the timer clock equals clk_sys
`timescale 1ns/1ns
`include "ctm_map.svh"
module test_compact_timer;
    import ctm_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] ha = '0;
    logic [1:0] ht = '0;
    logic hw = 1'b0;
    logic dp_rd = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] rv;
    logic lvl, o;
    logic [15:0] period_cyc, high_cyc;
    logic [63:0] exp_q[$];
    ahb_req_t ahb_req;
    ahb_rsp_t ahb_rsp;
    pin_t pin;
    int bad_count = 0;
    int cmp_count = 0;
    int seed = 12350;
    assign ahb_req = '{haddr: {20'h0, ha}, htrans: ht, hwrite: hw, hsize: 3'h2, hsel: 1'b1,
        hready: ahb_rsp.hreadyout};
    always #2 clk_sys = ~clk_sys;
    compact_timer i_compact_timer (.clk_sys(clk_sys), .rst_n(rst_n), .ahb_req(ahb_req),
        .hwdata(hwdata), .ahb_rsp(ahb_rsp), .pin(pin));
    ctm_load i_ctm_load (.clk_sys(clk_sys), .rst_n(rst_n), .pin(pin), .lvl(lvl),
        .period_cyc(period_cyc), .high_cyc(high_cyc));
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, e, s);
        end
    endtask
    // one single transfer; a read notes its expected word and mask for the watcher
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
        int n = 0;
        ha <= a;
        ht <= 2'b10;
        hw <= w;
        do @(posedge clk_sys); while (ahb_rsp.hreadyout !== 1'b1 && n++ < 50);
        ht <= 2'b00;
        hwdata <= d;
        dp_rd <= !w;
        if (!w) exp_q.push_back({d & m, m});
        do @(posedge clk_sys); while (ahb_rsp.hreadyout !== 1'b1 && n++ < 50);
        dp_rd <= 1'b0;
        // a bus that never answers is a mismatch, not a silent pass
        if (n >= 50) begin
            bad_count++;
            $display("unexpected hreadyout expected 1 seen %b", ahb_rsp.hreadyout);
        end
    endtask
    always @(posedge clk_sys) begin
        if (dp_rd && ahb_rsp.hreadyout === 1'b1 && exp_q.size() > 0) begin
            cmp("hrdata", exp_q[0][63:32], ahb_rsp.hrdata & exp_q[0][31:0]);
            void'(exp_q.pop_front());
        end
    end
    // stop first so the enable write is a rising edge
    task automatic setup(input logic [7:0] c1, input logic [9:0] a, input logic [7:0] c0);
        bus(1, `CTM_OFF_CTRL0, 32'h0, 32'h0);
        bus(1, `CTM_OFF_CTRL1, {24'h0, c1}, 32'h0);
        bus(1, `CTM_OFF_CMPA_LO, {24'h0, a[7:0]}, 32'h0);
        bus(1, `CTM_OFF_CMPA_HI, {30'h0, a[9:8]}, 32'h0);
        bus(1, `CTM_OFF_FLAGS, 32'h3, 32'h0);
        bus(1, `CTM_OFF_CTRL0, {24'h0, c0}, 32'h0);
    endtask
    task automatic measure(input int n, input logic [15:0] p, input logic [15:0] h);
        repeat (n) @(posedge clk_sys);
        cmp("period", {16'h0, p}, {16'h0, period_cyc});
        cmp("high time", {16'h0, h}, {16'h0, high_cyc});
    endtask
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        bus(0, `CTM_OFF_CNT_HI, 32'h0, 32'hffff_ffff);
        bus(0, `CTM_OFF_CMPA_LO, 32'h0, 32'hffff_ffff);
        bus(0, `CTM_OFF_CMPA_HI, 32'h0, 32'hffff_ffff);
        bus(0, 12'h020, 32'h0, 32'hffff_ffff);
        rv = $random(seed);
        bus(1, `CTM_OFF_CMPA_LO, rv, 32'h0);
        bus(1, `CTM_OFF_CMPA_HI, rv, 32'h0);
        bus(1, `CTM_OFF_CNT_HI, 32'h3, 32'h0);
        bus(0, `CTM_OFF_CMPA_LO, rv, 32'hff);
        bus(0, `CTM_OFF_CMPA_HI, rv, 32'hffff_ffff & 32'h3);
        bus(0, `CTM_OFF_CNT_HI, 32'h0, 32'hffff_ffff);
        setup(8'h31, 10'd3, 8'h09);
        measure(60, 16'd6, 16'd3);
        bus(0, `CTM_OFF_FLAGS, 32'h1, 32'h3);
        setup(8'h30, 10'd3, 8'h09);
        measure(700, 16'd256, 16'd128);
        bus(0, `CTM_OFF_FLAGS, 32'h3, 32'h3);
        for (int f = 0; f < 4; f++) begin
            o = rv[f];
            setup({2'b00, f[1:0], o, 3'b001}, 10'd200, 8'h08);
            repeat (3) @(posedge clk_sys);
            cmp("initial level", {31'h0, o}, {31'h0, pin.pin_out});
            repeat (300) @(posedge clk_sys);
            cmp("level after match", {31'h0, f == 0 ? o : f == 3 ? ~o : f == 2}, {31'h0, pin.pin_out});
        end
        setup(8'hc1, 10'd3, 8'h09);
        repeat (20) @(posedge clk_sys);
        cmp("pin enable", 32'h0, {31'h0, pin.pin_oe});
        bus(0, `CTM_OFF_FLAGS, 32'h1, 32'h1);
        setup(8'ha9, 10'd32, 8'h09);
        measure(400, 16'd128, 16'd32);
        bus(0, `CTM_OFF_FLAGS, 32'h3, 32'h3);
        setup(8'had, 10'd32, 8'h09);
        measure(400, 16'd128, 16'd96);
        setup(8'haa, 10'd300, 8'h09);
        measure(1000, 16'd300, 16'd128);
        for (int f = 0; f < 2; f++) begin
            setup({4'h8, f[1:0], 2'b00} | 8'h08, 10'd32, 8'h09);
            repeat (300) @(posedge clk_sys);
            cmp("forced level", f, {31'h0, pin.pin_out});
        end
        setup(8'haa, 10'd100, 8'h09);
        repeat (300) @(posedge clk_sys);
        cmp("full duty", 32'h1, {31'h0, pin.pin_out});
        end_sim();
    end
endmodule // test_compact_timer
